// >>> logic/ermds_pkg.sv
// constants of the expansion register map and device setting
package ermds_pkg;
	localparam int          ADDR_W          = 12;
	localparam int          REG_COUNT       = 10;
	// printed offsets kept as word indices; bus byte address is four times the index
	localparam logic [9:0]  IDX_DEV_SET     = 10'h000;
	localparam logic [9:0]  IDX_ENV1        = 10'h002;
	localparam logic [9:0]  IDX_ENV2        = 10'h004;
	localparam logic [9:0]  IDX_GPORT       = 10'h006;
	localparam logic [9:0]  IDX_RTC         = 10'h008;
	localparam logic [9:0]  IDX_SH0         = 10'h00C;
	localparam logic [9:0]  IDX_SH1         = 10'h00E;
	localparam logic [9:0]  IDX_SHS         = 10'h010;
	localparam logic [9:0]  IDX_BCS         = 10'h012;
	localparam logic [9:0]  IDX_IDC         = 10'h014;
	localparam logic [9:0]  IDX_RESERVED    = 10'h016;
	localparam logic [9:0]  IDX_OP_CMD      = 10'h040;
	localparam logic [9:0]  IDX_SYS_STAT    = 10'h041;
	// device setting fields
	localparam int          DEVNUM_LSB      = 0;
	localparam int          DEVNUM_W        = 6;
	localparam int          FIXED0_BIT      = 6;
	localparam int          MODE_BIT        = 7;
	localparam int          SEL_LSB         = 8;
	localparam int          SEL_W           = 5;
	localparam int          VCNT_LSB        = 13;
	localparam int          VCNT_W          = 3;
	localparam logic [15:0] DEV_WR_MASK     = 16'hFFBF;
	// system status fields
	localparam int          STAT_BUSY_BIT   = 0;
	localparam int          STAT_REFUSE_BIT = 1;
	// reset values
	localparam logic [15:0] REG16_RST       = 16'h0000;
	localparam logic [15:0] DEV_SET_RST     = 16'h0000;
	localparam logic [31:0] PORT_IN_RST     = 32'h0000_0001;
	localparam logic [31:0] PORT_ACT_RST    = 32'h0000_000F;
	// port attribute and communication stop command
	localparam int          PORT_COUNT      = 32;
	localparam logic [4:0]  SEL_CLAMP       = 5'h0F;
	localparam logic [7:0]  CMD_COMM_STOP   = 8'h11;
	// arbitrary identification value
	localparam logic [15:0] ID_CODE_DEF     = 16'hA5C3;
	// relative time counter tick
	localparam int          CLK_PERIOD_NS   = 50;
	localparam int          TICK_TIME_NS    = 1000;
	localparam int          TICK_CYCLES     = TICK_TIME_NS / CLK_PERIOD_NS;
endpackage : ermds_pkg

// >>> logic/ermds_cfg_if.sv
// device setting fields and decoded port attributes between register map and decoder
`timescale 1ns/1ps
interface ermds_cfg_if;
	logic [5:0]  devnum;
	logic [2:0]  vcnt;
	logic [4:0]  attr_sel;
	logic [31:0] port_input;
	logic [31:0] port_active;
	modport reg_side (output devnum, output vcnt, output attr_sel, input port_input,
		input port_active);
	modport dec_side (input devnum, input vcnt, input attr_sel, output port_input,
		output port_active);
endinterface : ermds_cfg_if

// >>> logic/ermds_port_attr.sv
// port attribute decoder: selector and virtual count to per-port direction
`timescale 1ns/1ps
module ermds_port_attr
	import ermds_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	ermds_cfg_if.dec_side   cfg
);
	typedef struct packed {
		logic [31:0] port_input;
		logic [31:0] port_active;
	} ermds_attr_t;

	ermds_attr_t s_reg;
	ermds_attr_t s_next;
	logic [4:0]  last_in;
	logic [5:0]  limit;
	logic [31:0] in_c;
	logic [31:0] act_c;

	// selectors above 01111b behave as 01111b
	assign last_in = cfg.attr_sel[4] ? SEL_CLAMP : cfg.attr_sel;
	// four byte ports per device, own device plus virtual ones
	assign limit = {4'(4'(cfg.vcnt) + 4'd1), 2'b00};

	for (genvar i = 0; i < PORT_COUNT; i++) begin : g_port
		// first n+1 ports input, beyond the configured devices ignored
		assign in_c[i]  = (5'(i) <= last_in) && (6'(i) < limit);
		assign act_c[i] = 6'(i) < limit;
	end

	always_comb begin
		s_next = s_reg;
		s_next.port_input = in_c;
		s_next.port_active = act_c;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg.port_input <= PORT_IN_RST;
			s_reg.port_active <= PORT_ACT_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign cfg.port_input = s_reg.port_input;
	assign cfg.port_active = s_reg.port_active;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	attr_clamp_a: assert property (cfg.attr_sel[4] |=> cfg.port_input[31:16] == 16'h0000)
		else $error("selector above 01111b gave more than sixteen inputs");
	first_input_a: assert property (cfg.port_input[0])
		else $error("first port not input");
	vdev_ignore_a: assert property ((cfg.vcnt == 3'd3) |=> cfg.port_active == 32'h0000_FFFF)
		else $error("ports beyond configured devices not ignored");
	attr_pattern_a: assert property ((cfg.attr_sel == 5'd5 && cfg.vcnt == 3'd7)
		|=> cfg.port_input == 32'h0000_003F)
		else $error("selector 5 did not give six input ports");
endmodule // ermds_port_attr

// >>> logic/ermds_time_ctr.sv
// free running relative time counter with divided tick
`timescale 1ns/1ps
module ermds_time_ctr
	import ermds_pkg::*;
#(
	parameter int TICKS = TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	output logic [31:0]      count
);
	typedef struct packed {
		logic [15:0] div;
		logic [31:0] count;
	} ermds_tmr_t;

	ermds_tmr_t s_reg;
	ermds_tmr_t s_next;

	always_comb begin
		s_next = s_reg;
		if (s_reg.div == 16'(TICKS - 1)) begin
			s_next.div = 16'h0000;
			s_next.count = s_reg.count + 32'h0000_0001;
		end else begin
			s_next.div = s_reg.div + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign count = s_reg.count;
endmodule // ermds_time_ctr

// >>> logic/ermds_top.sv
// What this block does
// - ten registers, offsets 0 to 20, step two, none at 10
// - time counter four bytes, others two
// - device setting writes ignored while busy
// - bits 5:0 device number, bit 6 zero
// - bit 7 picks message or monitor mode
// - bits 12:8 port attribute selector, all values
// - bits 15:13 virtual device count, consecutive
// - selector n makes first n+1 ports input
// - ports beyond configured devices are ignored
// - selectors 10000b up behave as 01111b
// - first port always input
// - input ports answer, output ports take requests
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module ermds_top
	import ermds_pkg::*;
#(
	parameter int          TICKS   = TICK_CYCLES,
	parameter logic [15:0] ID_CODE = ID_CODE_DEF
) (
	input  wire logic                REF_CLK,
	input  wire logic                RESET_N,
	input  wire logic                PSEL,
	input  wire logic                PENABLE,
	input  wire logic                PWRITE,
	input  wire logic [ADDR_W-1:0]   PADDR,
	input  wire logic [31:0]         PWDATA,
	input  wire logic [3:0]          PSTRB,
	output logic                     PREADY,
	output logic [31:0]              PRDATA,
	output logic                     PSLVERR,
	input  wire logic                SYS_BUSY,
	output logic                     OP_CMD_STROBE,
	output logic [7:0]               OP_CMD_CODE,
	output logic [5:0]               DEVICE_NUMBER,
	output logic                     MONITOR_MODE,
	output logic [4:0]               PORT_ATTR_SEL,
	output logic [2:0]               VIRTUAL_COUNT,
	output logic [31:0]              PORT_INPUT,
	output logic [31:0]              PORT_ACTIVE
);
	typedef struct packed {
		logic [15:0] dev;
		logic [15:0] env1;
		logic [15:0] env2;
		logic [15:0] gport;
		logic [15:0] sh0;
		logic [15:0] sh1;
		logic [15:0] shs;
		logic [15:0] bcs;
		logic        busy_s1;
		logic        busy_s2;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic        wr_ok;
		logic        refused;
		logic        cmd_strobe;
		logic [7:0]  cmd_code;
	} ermds_main_t;

	ermds_main_t s_reg;
	ermds_main_t s_next;
	logic [31:0] rtc_count;
	logic [9:0]  idx;
	logic        aligned;
	logic        mapped;
	logic        dev_hit;
	logic        ro_hit;
	logic        stat_hit;
	logic        setup;
	logic        access;
	logic        locked;
	logic [31:0] rd_word;

	ermds_cfg_if cfg ();

	ermds_port_attr u_port_attr (
		.clk     (REF_CLK),
		.reset_n (RESET_N),
		.cfg     (cfg.dec_side)
	);

	ermds_time_ctr #(
		.TICKS   (TICKS)
	) u_time_ctr (
		.clk     (REF_CLK),
		.reset_n (RESET_N),
		.count   (rtc_count)
	);

	// merge a byte-lane write into a 16-bit register
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] wdata,
		input logic [3:0]  strb
	);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = wdata[7:0];
		end
		if (strb[1]) begin
			res[15:8] = wdata[15:8];
		end
		return res;
	endfunction

	assign idx = PADDR[ADDR_W-1:2];
	assign aligned = PADDR[1:0] == 2'b00;
	assign setup = PSEL && !PENABLE;
	assign access = PSEL && PENABLE && s_reg.pready;
	assign locked = s_reg.busy_s2;

	// address decode: the ten words plus command and status
	always_comb begin
		mapped = aligned;
		dev_hit = 1'b0;
		ro_hit = 1'b0;
		stat_hit = 1'b0;
		rd_word = 32'h0000_0000;
		if (idx == IDX_DEV_SET) begin
			dev_hit = 1'b1;
			rd_word = {16'h0000, s_reg.dev};
		end else if (idx == IDX_ENV1) begin
			rd_word = {16'h0000, s_reg.env1};
		end else if (idx == IDX_ENV2) begin
			rd_word = {16'h0000, s_reg.env2};
		end else if (idx == IDX_GPORT) begin
			rd_word = {16'h0000, s_reg.gport};
		end else if (idx == IDX_RTC) begin
			ro_hit = 1'b1;
			rd_word = rtc_count;
		end else if (idx == IDX_SH0) begin
			rd_word = {16'h0000, s_reg.sh0};
		end else if (idx == IDX_SH1) begin
			rd_word = {16'h0000, s_reg.sh1};
		end else if (idx == IDX_SHS) begin
			rd_word = {16'h0000, s_reg.shs};
		end else if (idx == IDX_BCS) begin
			rd_word = {16'h0000, s_reg.bcs};
		end else if (idx == IDX_IDC) begin
			ro_hit = 1'b1;
			rd_word = {16'h0000, ID_CODE};
		end else if (idx == IDX_OP_CMD) begin
			rd_word = {24'h00_0000, s_reg.cmd_code};
		end else if (idx == IDX_SYS_STAT) begin
			stat_hit = 1'b1;
			rd_word[STAT_BUSY_BIT] = s_reg.busy_s2;
			rd_word[STAT_REFUSE_BIT] = s_reg.refused;
		end else begin
			// every unlisted word, such as the gap at 10 or space from offset 22 up other than command and status, answers with an error
			mapped = 1'b0;
		end
		if (!aligned) begin
			mapped = 1'b0;
		end
	end

	always_comb begin
		s_next = s_reg;
		s_next.busy_s1 = SYS_BUSY;
		s_next.busy_s2 = s_reg.busy_s1;
		s_next.cmd_strobe = 1'b0;
		s_next.pready = setup;
		if (setup) begin
			s_next.prdata = (mapped && !PWRITE) ? rd_word : 32'h0000_0000;
			// a refused setting write is reported, the register keeps its value
			s_next.pslverr = !mapped || (PWRITE && dev_hit && locked);
			// read-only words take the write silently without side effect
			s_next.wr_ok = PWRITE && mapped && !ro_hit && !(dev_hit && locked);
			if (PWRITE && mapped && dev_hit && locked) begin
				s_next.refused = 1'b1;
			end
		end
		if (access && s_reg.wr_ok) begin
			if (idx == IDX_DEV_SET) begin
				// bit 6 stays zero whatever is written
				s_next.dev = merge16(s_reg.dev, PWDATA, PSTRB) & DEV_WR_MASK;
			end else if (idx == IDX_ENV1) begin
				s_next.env1 = merge16(s_reg.env1, PWDATA, PSTRB);
			end else if (idx == IDX_ENV2) begin
				s_next.env2 = merge16(s_reg.env2, PWDATA, PSTRB);
			end else if (idx == IDX_GPORT) begin
				s_next.gport = merge16(s_reg.gport, PWDATA, PSTRB);
			end else if (idx == IDX_SH0) begin
				s_next.sh0 = merge16(s_reg.sh0, PWDATA, PSTRB);
			end else if (idx == IDX_SH1) begin
				s_next.sh1 = merge16(s_reg.sh1, PWDATA, PSTRB);
			end else if (idx == IDX_SHS) begin
				s_next.shs = merge16(s_reg.shs, PWDATA, PSTRB);
			end else if (idx == IDX_BCS) begin
				s_next.bcs = merge16(s_reg.bcs, PWDATA, PSTRB);
			end else if (idx == IDX_OP_CMD) begin
				if (PSTRB[0]) begin
					s_next.cmd_code = PWDATA[7:0];
					s_next.cmd_strobe = 1'b1;
				end
			end else if (stat_hit) begin
				// a refusal in the same cycle as the clear still sets the flag
				if (PSTRB[0] && PWDATA[STAT_REFUSE_BIT] && !(setup && s_next.refused)) begin
					s_next.refused = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_reg <= '0;
			s_reg.dev <= DEV_SET_RST;
			s_reg.env1 <= REG16_RST;
			s_reg.env2 <= REG16_RST;
			s_reg.gport <= REG16_RST;
			s_reg.sh0 <= REG16_RST;
			s_reg.sh1 <= REG16_RST;
			s_reg.shs <= REG16_RST;
			s_reg.bcs <= REG16_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign cfg.devnum = s_reg.dev[DEVNUM_LSB +: DEVNUM_W];
	assign cfg.attr_sel = s_reg.dev[SEL_LSB +: SEL_W];
	assign cfg.vcnt = s_reg.dev[VCNT_LSB +: VCNT_W];

	assign PREADY = s_reg.pready;
	assign PRDATA = s_reg.prdata;
	assign PSLVERR = s_reg.pslverr;
	assign OP_CMD_STROBE = s_reg.cmd_strobe;
	assign OP_CMD_CODE = s_reg.cmd_code;
	assign DEVICE_NUMBER = s_reg.dev[DEVNUM_LSB +: DEVNUM_W];
	assign MONITOR_MODE = s_reg.dev[MODE_BIT];
	assign PORT_ATTR_SEL = s_reg.dev[SEL_LSB +: SEL_W];
	assign VIRTUAL_COUNT = s_reg.dev[VCNT_LSB +: VCNT_W];
	// input ports return local data, output ports carry request data
	assign PORT_INPUT = cfg.port_input;
	assign PORT_ACTIVE = cfg.port_active;

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	sequence dev_setup_locked;
		PSEL && !PENABLE && PWRITE && PADDR == {IDX_DEV_SET, 2'b00} && s_reg.busy_s2;
	endsequence
	sequence dev_setup_free;
		PSEL && !PENABLE && PWRITE && PADDR == {IDX_DEV_SET, 2'b00} && !s_reg.busy_s2
			&& PSTRB[0];
	endsequence
	sequence access_done;
		PSEL && PENABLE && PREADY;
	endsequence

	apb_ready_a: assert property ((PSEL && !PENABLE) |=> PREADY ##1 !PREADY)
		else $error("ready not given exactly one cycle after setup");
	id_read_a: assert property ((PSEL && !PENABLE && !PWRITE && PADDR == {IDX_IDC, 2'b00})
		|=> PRDATA == {16'h0000, ID_CODE} && !PSLVERR)
		else $error("identification word misread");
	narrow_read_a: assert property ((PSEL && !PENABLE && !PWRITE && PADDR != {IDX_RTC, 2'b00})
		|=> PRDATA[31:16] == 16'h0000)
		else $error("upper half of a two-byte register not zero");
	rsv_error_a: assert property ((PSEL && !PENABLE && PADDR == {IDX_RESERVED, 2'b00})
		|=> PSLVERR)
		else $error("reserved word accepted");
	busy_lock_a: assert property (dev_setup_locked ##1 access_done
		|=> $stable(DEVICE_NUMBER) && $stable(PORT_ATTR_SEL) && $stable(MONITOR_MODE))
		else $error("device setting changed while busy");
	busy_err_a: assert property (dev_setup_locked |=> PSLVERR ##1 s_reg.refused)
		else $error("busy write not reported");
	fixed_zero_a: assert property ((PSEL && !PENABLE && !PWRITE && PADDR == {IDX_DEV_SET, 2'b00})
		|=> !PRDATA[FIXED0_BIT])
		else $error("fixed zero bit read as one");
	mode_out_a: assert property (dev_setup_free ##1 access_done
		|=> MONITOR_MODE == $past(PWDATA[MODE_BIT]) && DEVICE_NUMBER == $past(PWDATA[5:0]))
		else $error("mode or device number not taken from write");
	ro_write_a: assert property ((PSEL && !PENABLE && PWRITE && PADDR == {IDX_RTC, 2'b00})
		|=> !PSLVERR ##1 $stable(s_reg.dev))
		else $error("write to read-only word had an effect");
endmodule // ermds_top

// >>> dv/ermds_engine_model.sv
// behavioural communication engine answering operation commands with a busy flag
`timescale 1ns/1ps
module ermds_engine_model (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       cmd_strobe,
	input  wire logic [7:0] cmd_code,
	input  wire logic [7:0] delay,
	output logic            busy
);
	int   cnt_reg;
	logic target_reg;
	// delay input lets the bench make the engine answer promptly or slowly
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy       <= 1'b0;
			cnt_reg    <= 0;
			target_reg <= 1'b0;
		end else if (cmd_strobe) begin
			target_reg <= (cmd_code != 8'h11);
			cnt_reg    <= int'(delay);
		end else if (cnt_reg > 0) begin
			cnt_reg <= cnt_reg - 1;
			if (cnt_reg == 1) busy <= target_reg;
		end
	end
endmodule // ermds_engine_model

// >>> dv/tb.sv
// self-checking bench for the expansion register map over apb
`timescale 1ns/1ps
module tb;
	import ermds_pkg::*;
	localparam int          TK  = 2;
	localparam logic [15:0] IDV = 16'h3C5A; // arbitrary identification value
	logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [7:0]  dly = 8'h01;
	logic        pready, pslverr, strobe, mon, busy, err;
	logic [31:0] prdata, pin, pact, rd, t0;
	logic [7:0]  code;
	logic [5:0]  devnum;
	logic [4:0]  sel;
	logic [2:0]  vc;
	logic [15:0] v;
	int          fail_count = 0, comparisons = 0, cyc = 0;
	logic [9:0]  rw [8] = '{IDX_DEV_SET, IDX_ENV1, IDX_ENV2, IDX_GPORT,
		IDX_SH0, IDX_SH1, IDX_SHS, IDX_BCS};

	always #25 clk = ~clk;

	ermds_top #(.TICKS(TK), .ID_CODE(IDV)) uut (
		.REF_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF),
		.PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .SYS_BUSY(busy),
		.OP_CMD_STROBE(strobe), .OP_CMD_CODE(code), .DEVICE_NUMBER(devnum),
		.MONITOR_MODE(mon), .PORT_ATTR_SEL(sel), .VIRTUAL_COUNT(vc),
		.PORT_INPUT(pin), .PORT_ACTIVE(pact)
	);

	ermds_engine_model engine (
		.clk(clk), .reset_n(rst_n), .cmd_strobe(strobe), .cmd_code(code),
		.delay(dly), .busy(busy)
	);

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			end_sim();
		end
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [11:0] ba(input logic [9:0] i);
		return {i, 2'b00};
	endfunction

	function automatic logic [31:0] ones(input int n);
		return (n >= 32) ? 32'hFFFF_FFFF : ((32'h1 << n) - 32'h1);
	endfunction

	// one apb transfer; the request is held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) check("pready", 32'h0, 32'h1);
	endtask

	task automatic rdc(input string nm, input logic [9:0] i, input logic [31:0] exp,
		input logic e);
		apb(1'b0, ba(i), '0);
		check(nm, rd, exp);
		check({nm, " err"}, 32'(err), 32'(e));
	endtask

	task automatic poll(input logic b);
		int k;
		k = 0;
		do begin
			apb(1'b0, ba(IDX_SYS_STAT), '0);
			k++;
		end while (rd[0] !== b && k < 40);
		check("busy", 32'(rd[0]), 32'(b));
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		check("input rst", pin, 32'h1);
		check("active rst", pact, 32'hF);
		foreach (rw[i]) rdc("reset", rw[i], 32'h0, 1'b0);
		rdc("id", IDX_IDC, {16'h0, IDV}, 1'b0);
		foreach (rw[i]) begin
			apb(1'b1, ba(rw[i]), 32'hFFFF_FFFF);
			rdc("rw", rw[i], (i == 0) ? 32'hFFBF : 32'hFFFF, 1'b0);
		end
		$display("test registers done");

		// read-only places: time counter keeps counting, id keeps its value
		apb(1'b0, ba(IDX_RTC), '0);
		t0 = rd;
		repeat (20) @(posedge clk);
		apb(1'b1, ba(IDX_RTC), 32'h0);
		check("rtc wr err", 32'(err), 32'h0);
		apb(1'b0, ba(IDX_RTC), '0);
		check("rtc step", rd - t0, 32'd13);
		apb(1'b1, ba(IDX_IDC), 32'h0);
		rdc("id wr", IDX_IDC, {16'h0, IDV}, 1'b0);
		$display("test read only done");

		rdc("gap", 10'h009, 32'h0, 1'b1);
		rdc("reserved", IDX_RESERVED, 32'h0, 1'b1);
		apb(1'b0, 12'h001, '0);
		check("misaligned err", 32'(err), 32'h1);
		$display("test unmapped done");

		// lock: start traffic, try a write, stop traffic, then clear the refusal flag
		dly <= 8'h01;
		apb(1'b1, ba(IDX_OP_CMD), 32'h01);
		poll(1'b1);
		apb(1'b1, ba(IDX_DEV_SET), 32'h0123);
		check("locked err", 32'(err), 32'h1);
		rdc("locked", IDX_DEV_SET, 32'hFFBF, 1'b0);
		rdc("refused", IDX_SYS_STAT, 32'h3, 1'b0);
		dly <= 8'h0C;
		apb(1'b1, ba(IDX_OP_CMD), {24'h0, CMD_COMM_STOP});
		@(posedge clk);
		check("cmd strobe", 32'(strobe), 32'h1);
		check("cmd code", 32'(code), 32'h11);
		poll(1'b0);
		apb(1'b1, ba(IDX_SYS_STAT), 32'h2);
		rdc("refused clr", IDX_SYS_STAT, 32'h0, 1'b0);
		$display("test lock done");

		// every selector code with varied device number, mode and virtual count
		for (int p = 0; p < 32; p++) begin
			v = {3'(p * 3), 5'(p), p[0], 1'b1, 6'(p * 2 + 1)};
			apb(1'b1, ba(IDX_DEV_SET), {16'h0, v});
			check("set err", 32'(err), 32'h0);
			repeat (3) @(posedge clk);
			check("devnum", 32'(devnum), 32'(v[5:0]));
			check("mode", 32'(mon), 32'(v[7]));
			check("sel", 32'(sel), 32'(v[12:8]));
			check("vcnt", 32'(vc), 32'(v[15:13]));
			check("active", pact, ones((int'(v[15:13]) + 1) * 4));
			check("input", pin, ones((v[12] ? 15 : int'(v[11:8])) + 1)
				& ones((int'(v[15:13]) + 1) * 4));
			rdc("dev rb", IDX_DEV_SET, {16'h0, v & 16'hFFBF}, 1'b0);
		end
		$display("test port attributes done");
		end_sim();
	end
endmodule // tb
